// [design/wr_crc_pkg.sv]
// package: shared constants for the write checksum link and its two ends
// assumes: one 20 MHz clock for both ends, synchronous active-low reset
`default_nettype none
package wr_crc_pkg;
   // ----------------------------------------------------------------
   // burst shape (burst_chop_four, x8 lanes)
   // ----------------------------------------------------------------
   localparam int DQ_W = 8;
   localparam int TREE_W = 72;
   localparam int MASK_BASE = 64;
   localparam int DATA_BEATS = 4;
   localparam int UPPER_OFS = 4;
   localparam logic [3:0] BEAT_CRC = 4'h8;
   localparam logic [3:0] BEAT_LAST = 4'h9;
   localparam logic [7:0] CRC_POLY = 8'h07;
   // ----------------------------------------------------------------
   // alert timing in clock cycles
   // ----------------------------------------------------------------
   localparam logic [7:0] CRC_PULSE_W = 8'h06;
   localparam logic [7:0] PAR_PULSE_W = 8'h30;
   localparam logic [7:0] PAR_LIMIT = 8'h2d;
   // ----------------------------------------------------------------
   // mode register access over the link
   // ----------------------------------------------------------------
   localparam logic [2:0] MRS_SEL_FIVE = 3'h5;
   localparam int MR5_ERR_BIT = 3;
   localparam int PURPOSE_REGISTER_THREE_ERR_BIT = 7;
   localparam logic [1:0] RD_SEL_MR5 = 2'h1;
   localparam logic [1:0] RD_SEL_PURPOSE_REGISTER_THREE_P1 = 2'h2;
   // ----------------------------------------------------------------
   // controller registers on wishbone (byte addresses)
   // ----------------------------------------------------------------
   localparam logic [7:0] ADR_CTRL = 8'h00;
   localparam logic [7:0] ADR_WDATA = 8'h04;
   localparam logic [7:0] ADR_CMD = 8'h08;
   localparam logic [7:0] ADR_STAT = 8'h0c;
   localparam int CTRL_A2 = 1;
   localparam int CTRL_INJECT = 2;
   localparam int CTRL_RETRY = 5;
   localparam int CTRL_MSK_EN = 6;
   localparam int CTRL_MASK_LO = 8;
   localparam int CMD_WRITE = 0;
   localparam int CMD_CLEAR = 1;
   localparam int CMD_RD_MR5 = 2;
   localparam int CMD_RD_PURPOSE_REGISTER_THREE = 3;
   localparam int ST_BUSY = 0;
   localparam int ST_CRC = 1;
   localparam int ST_PAR = 2;
   localparam int ST_RETRY = 3;
   localparam logic [31:0] CTRL_RST = 32'h0000_0f20;
endpackage : wr_crc_pkg
`default_nettype wire

// [design/wr_crc_link.sv]
// interface: write burst, mode register and shared alert wire between the ends
// assumes: the pull-up on the alert wire lives here; no other drivers modelled
`default_nettype none
interface wr_crc_link;
   logic wr_valid;
   logic [7:0] dq;
   logic write_mask_pin;
   logic column_address_bit_two;
   logic mrs_valid;
   logic [2:0] mrs_sel;
   logic [7:0] mrs_data;
   logic rd_req;
   logic [1:0] rd_sel;
   logic [7:0] rd_data;
   logic rd_ack;
   logic alert_o;
   logic alert_oe;
   logic alert_n;
   // pull-up: released line reads high
   assign alert_n = alert_oe ? alert_o : 1'b1;
   modport device (
      input wr_valid, dq, write_mask_pin, column_address_bit_two,
      input mrs_valid, mrs_sel, mrs_data, rd_req, rd_sel,
      output rd_data, rd_ack, alert_o, alert_oe
   );
   modport controller (
      output wr_valid, dq, write_mask_pin, column_address_bit_two,
      output mrs_valid, mrs_sel, mrs_data, rd_req, rd_sel,
      input rd_data, rd_ack, alert_n
   );
endinterface : wr_crc_link
`default_nettype wire

// [design/crc_tree.sv]
// checksum tree: 72 inputs folded to 8 bits
// assumes: caller already placed constant ones on unused positions
`default_nettype none
module crc_tree
   import wr_crc_pkg::*;
(
   // tree inputs
   input wire logic [wr_crc_pkg::TREE_W-1:0] tree_i,
   // checksum
   output logic [7:0] crc_o
);
   // serial form unrolls to one xor subset per bit; bit 0 enters first
   function automatic logic [7:0] fold(input logic [TREE_W-1:0] d);
      logic [7:0] c;
      logic fb;
      c = 8'h00;
      for (int i = 0; i < TREE_W; i++) begin
         fb = c[7] ^ d[i];
         c = {c[6:0], 1'b0} ^ (fb ? CRC_POLY : 8'h00);
      end
      return c;
   endfunction : fold

   assign crc_o = fold(tree_i);
endmodule : crc_tree
`default_nettype wire

// [design/wr_crc_device.sv]
// memory-device end: gathers write bursts, checks the checksum, drives alert
// assumes: controller sends ten consecutive transfers per burst and clears the
// error bit by a mode register write; the alert pull-up lives in the link interface
`default_nettype none

module wr_crc_device
   import wr_crc_pkg::*;
(
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // link to controller
   wr_crc_link.device link,
   // device configuration
   input wire logic mask_en_i,
   input wire logic inv_en_i,
   // command/address parity event from the decoder
   input wire logic parity_err_i,
   // write data towards the array
   output logic [31:0] wr_data_o,
   output logic wr_valid_o,
   // error status
   output logic crc_err_o
);
   import wr_crc_pkg::*;

   // ----------------------------------------------------------------
   // types and state
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      AL_IDLE = 3'b001,
      AL_CRC = 3'b010,
      AL_PAR = 3'b100
   } alert_e;

   alert_e alert_ff;
   alert_e nxt_alert;
   logic [7:0] pulse_cnt_ff;
   logic [7:0] nxt_pulse_cnt;
   logic alert_oe_ff;
   logic [3:0] beat_ff;
   logic in_burst_ff;
   logic upper_ff;
   logic upper_cur;
   logic [TREE_W-1:0] tree_ff;
   logic [TREE_W-1:0] nxt_tree;
   logic [31:0] data_ff;
   logic [31:0] nxt_data;
   logic [7:0] crc_calc;
   logic mismatch;
   logic burst_err_ff;
   logic status_ff;
   logic wr_valid_ff;
   logic [7:0] rd_data_ff;
   logic rd_ack_ff;
   logic clear_req;
   logic [3:0] beat_cur;

   // ----------------------------------------------------------------
   // burst gathering
   // ----------------------------------------------------------------
   // a transfer outside a burst always starts a new one at beat zero
   assign beat_cur = in_burst_ff ? beat_ff : 4'h0;
   assign upper_cur = (beat_cur == 4'h0) ? link.column_address_bit_two : upper_ff;

   always_comb begin
      int ofs;
      int b;
      ofs = upper_cur ? UPPER_OFS : 0;
      b = int'(beat_cur);
      nxt_tree = (beat_cur == 4'h0) ? '1 : tree_ff;
      nxt_data = data_ff;
      if (link.wr_valid && beat_cur < 4'(DATA_BEATS)) begin
         for (int k = 0; k < DQ_W; k++) begin
            nxt_tree[8 * k + ofs + b] = link.dq[k];
            nxt_data[8 * b + k] = link.dq[k];
         end
         // pin carries nothing when both functions are off
         nxt_tree[MASK_BASE + ofs + b] = (mask_en_i || inv_en_i) ?
            link.write_mask_pin : 1'b1;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         beat_ff <= 4'h0;
         in_burst_ff <= 1'b0;
         upper_ff <= 1'b0;
      end else if (link.wr_valid) begin
         upper_ff <= upper_cur;
         if (beat_cur == BEAT_LAST) begin
            beat_ff <= 4'h0;
            in_burst_ff <= 1'b0;
         end else begin
            beat_ff <= beat_cur + 4'h1;
            in_burst_ff <= 1'b1;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         tree_ff <= '1;
         data_ff <= 32'h0000_0000;
      end else if (link.wr_valid) begin
         tree_ff <= nxt_tree;
         data_ff <= nxt_data;
      end
   end

   // ----------------------------------------------------------------
   // checksum compare
   // ----------------------------------------------------------------
   crc_tree u_tree (
      .tree_i(tree_ff),
      .crc_o(crc_calc)
   );

   // tree is complete after beat three, so the compare is valid at the crc beat
   assign mismatch = link.wr_valid && (beat_cur == BEAT_CRC) &&
      (crc_calc != link.dq);

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         burst_err_ff <= 1'b0;
      end else if (mismatch) begin
         burst_err_ff <= 1'b1;
      end else if (link.wr_valid && beat_cur == 4'h0) begin
         burst_err_ff <= 1'b0;
      end
   end

   // with masking on, a failed burst is held back from the array
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         wr_valid_ff <= 1'b0;
      end else begin
         wr_valid_ff <= link.wr_valid && (beat_cur == BEAT_LAST) &&
            !(mask_en_i && burst_err_ff);
      end
   end

   // ----------------------------------------------------------------
   // error status: mode register five, mirrored in purpose register three
   // ----------------------------------------------------------------
   assign clear_req = link.mrs_valid && (link.mrs_sel == MRS_SEL_FIVE) &&
      !link.mrs_data[MR5_ERR_BIT];

   // a new mismatch beats a clear in the same cycle
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         status_ff <= 1'b0;
      end else if (mismatch) begin
         status_ff <= 1'b1;
      end else if (clear_req) begin
         status_ff <= 1'b0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         rd_data_ff <= 8'h00;
         rd_ack_ff <= 1'b0;
      end else begin
         rd_ack_ff <= link.rd_req;
         if (link.rd_req) begin
            rd_data_ff <= 8'h00;
            if (link.rd_sel == RD_SEL_MR5) begin
               rd_data_ff[MR5_ERR_BIT] <= status_ff;
            end else if (link.rd_sel == RD_SEL_PURPOSE_REGISTER_THREE_P1) begin
               rd_data_ff[PURPOSE_REGISTER_THREE_ERR_BIT] <= status_ff;
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // alert generator
   // ----------------------------------------------------------------
   // parity wins: its long pulse already covers any checksum report
   always_comb begin
      nxt_alert = alert_ff;
      nxt_pulse_cnt = pulse_cnt_ff;
      case (alert_ff)
         AL_IDLE: begin
            if (parity_err_i) begin
               nxt_alert = AL_PAR;
               nxt_pulse_cnt = PAR_PULSE_W;
            end else if (mismatch) begin
               nxt_alert = AL_CRC;
               nxt_pulse_cnt = CRC_PULSE_W;
            end
         end
         AL_CRC: begin
            if (parity_err_i) begin
               nxt_alert = AL_PAR;
               nxt_pulse_cnt = PAR_PULSE_W;
            end else if (mismatch) begin
               nxt_pulse_cnt = CRC_PULSE_W;
            end else if (pulse_cnt_ff == 8'h01) begin
               nxt_alert = AL_IDLE;
               nxt_pulse_cnt = 8'h00;
            end else begin
               nxt_pulse_cnt = pulse_cnt_ff - 8'h01;
            end
         end
         AL_PAR: begin
            if (pulse_cnt_ff == 8'h01) begin
               nxt_alert = AL_IDLE;
               nxt_pulse_cnt = 8'h00;
            end else begin
               nxt_pulse_cnt = pulse_cnt_ff - 8'h01;
            end
         end
         default: begin
            nxt_alert = AL_IDLE;
            nxt_pulse_cnt = 8'h00;
         end
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         alert_ff <= AL_IDLE;
         pulse_cnt_ff <= 8'h00;
         alert_oe_ff <= 1'b0;
      end else begin
         alert_ff <= nxt_alert;
         pulse_cnt_ff <= nxt_pulse_cnt;
         alert_oe_ff <= (nxt_alert != AL_IDLE);
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   // open drain: only ever drives low, release is left to the pull-up
   assign link.alert_o = 1'b0;
   assign link.alert_oe = alert_oe_ff;
   assign link.rd_data = rd_data_ff;
   assign link.rd_ack = rd_ack_ff;
   assign wr_data_o = data_ff;
   assign wr_valid_o = wr_valid_ff;
   assign crc_err_o = status_ff;
endmodule : wr_crc_device
`default_nettype wire

// [design/wr_crc_controller.sv]
// controller end: wishbone slave that issues bursts, clears and reads status,
// measures alert width and replays the last burst
// assumes: the alert wire is resolved by the link interface on the same clock
`default_nettype none
module wr_crc_controller
   import wr_crc_pkg::*;
(
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // wishbone classic slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // link to device
   wr_crc_link.controller link
);
   import wr_crc_pkg::*;

   typedef enum logic [3:0] {
      H_IDLE = 4'b0001,
      H_BURST = 4'b0010,
      H_MRS = 4'b0100,
      H_READ = 4'b1000
   } host_e;

   host_e st_ff;
   logic [31:0] ctrl_ff;
   logic [31:0] wdata_ff;
   logic ack_ff;
   logic [31:0] dat_ff;
   logic [3:0] beat_ff;
   logic [7:0] crc_ref;
   logic [TREE_W-1:0] tree;
   logic wr_ff;
   logic [7:0] dq_ff;
   logic pin_ff;
   logic a2_ff;
   logic mrs_ff;
   logic rd_ff;
   logic [1:0] rd_sel_ff;
   logic [7:0] rd_val_ff;
   logic alert_q_ff;
   logic [7:0] low_cnt_ff;
   logic [7:0] width_ff;
   logic crc_seen_ff;
   logic par_seen_ff;
   logic retry_ff;
   logic replay_ff;
   logic wr_req;
   logic cmd_wr;
   logic stat_wr;
   logic alert_end;
   logic crc_end;

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] sel);
      for (int i = 0; i < 4; i++) begin
         if (sel[i]) begin
            old[8 * i +: 8] = nw[8 * i +: 8];
         end
      end
      return old;
   endfunction : merge

   // byte driven on a beat; ones outside data and checksum transfers
   function automatic logic [7:0] beat_byte(input logic [3:0] b, input logic [31:0] d,
                                           input logic [7:0] c);
      if (b < 4'(DATA_BEATS)) begin
         return d[8 * int'(b) +: 8];
      end else if (b == BEAT_CRC) begin
         return c;
      end
      return 8'hff;
   endfunction : beat_byte

   // ----------------------------------------------------------------
   // wishbone slave: ack one cycle after the strobe, dropped next cycle
   // ----------------------------------------------------------------
   assign wr_req = wb_cyc_i && wb_stb_i && !ack_ff && wb_we_i;
   assign cmd_wr = wr_req && (wb_adr_i == ADR_CMD) && wb_sel_i[0];
   assign stat_wr = wr_req && (wb_adr_i == ADR_STAT) && wb_sel_i[0];

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         ack_ff <= 1'b0;
         dat_ff <= 32'h0000_0000;
         ctrl_ff <= CTRL_RST;
         wdata_ff <= 32'h0000_0000;
      end else begin
         ack_ff <= wb_cyc_i && wb_stb_i && !ack_ff;
         dat_ff <= 32'h0000_0000;
         if (wr_req && wb_adr_i == ADR_CTRL) begin
            ctrl_ff <= merge(ctrl_ff, wb_dat_i, wb_sel_i);
         end else if (wr_req && wb_adr_i == ADR_WDATA) begin
            wdata_ff <= merge(wdata_ff, wb_dat_i, wb_sel_i);
         end
         if (wb_adr_i == ADR_CTRL) begin
            dat_ff <= ctrl_ff;
         end else if (wb_adr_i == ADR_WDATA) begin
            dat_ff <= wdata_ff;
         end else if (wb_adr_i == ADR_STAT) begin
            dat_ff <= {8'h00, rd_val_ff, width_ff, 4'h0, retry_ff, par_seen_ff,
                       crc_seen_ff, st_ff != H_IDLE};
         end
      end
   end

   // ----------------------------------------------------------------
   // burst checksum over the same tree the device uses
   // ----------------------------------------------------------------
   always_comb begin
      int ofs;
      ofs = ctrl_ff[CTRL_A2] ? UPPER_OFS : 0;
      tree = '1;
      for (int b = 0; b < DATA_BEATS; b++) begin
         for (int k = 0; k < DQ_W; k++) begin
            tree[8 * k + ofs + b] = wdata_ff[8 * b + k];
         end
         tree[MASK_BASE + ofs + b] = ctrl_ff[CTRL_MSK_EN] ?
            ctrl_ff[CTRL_MASK_LO + b] : 1'b1;
      end
   end

   crc_tree u_tree (
      .tree_i(tree),
      .crc_o(crc_ref)
   );

   // ----------------------------------------------------------------
   // command sequencer; commands while busy are dropped
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         st_ff <= H_IDLE;
         beat_ff <= 4'h0;
         wr_ff <= 1'b0;
         dq_ff <= 8'hff;
         pin_ff <= 1'b1;
         a2_ff <= 1'b0;
         mrs_ff <= 1'b0;
         rd_ff <= 1'b0;
         rd_sel_ff <= 2'h0;
         rd_val_ff <= 8'h00;
         replay_ff <= 1'b0;
      end else begin
         mrs_ff <= 1'b0;
         rd_ff <= 1'b0;
         case (st_ff)
            H_IDLE: begin
               if ((cmd_wr && wb_dat_i[CMD_WRITE]) || retry_ff) begin
                  st_ff <= H_BURST;
                  beat_ff <= 4'h0;
                  wr_ff <= 1'b1;
                  a2_ff <= ctrl_ff[CTRL_A2];
                  // retry drops as the replay starts, so remember it for the whole burst
                  replay_ff <= retry_ff;
                  dq_ff <= beat_byte(4'h0, wdata_ff, crc_ref);
                  pin_ff <= ctrl_ff[CTRL_MASK_LO];
               end else if (cmd_wr && wb_dat_i[CMD_CLEAR]) begin
                  st_ff <= H_MRS;
                  mrs_ff <= 1'b1;
               end else if (cmd_wr && (wb_dat_i[CMD_RD_MR5] || wb_dat_i[CMD_RD_PURPOSE_REGISTER_THREE])) begin
                  st_ff <= H_READ;
                  rd_ff <= 1'b1;
                  rd_sel_ff <= wb_dat_i[CMD_RD_MR5] ? RD_SEL_MR5 : RD_SEL_PURPOSE_REGISTER_THREE_P1;
               end
            end
            H_BURST: begin
               if (beat_ff == BEAT_LAST) begin
                  st_ff <= H_IDLE;
                  wr_ff <= 1'b0;
                  dq_ff <= 8'hff;
                  pin_ff <= 1'b1;
               end else begin
                  beat_ff <= beat_ff + 4'h1;
                  dq_ff <= beat_byte(beat_ff + 4'h1, wdata_ff, crc_ref) ^
                     ((beat_ff + 4'h1 == BEAT_CRC && ctrl_ff[CTRL_INJECT] && !replay_ff) ?
                      8'h01 : 8'h00);
                  pin_ff <= (beat_ff + 4'h1 < 4'(DATA_BEATS)) ?
                     ctrl_ff[CTRL_MASK_LO + int'(beat_ff) + 1] : 1'b1;
               end
            end
            H_MRS: begin
               st_ff <= H_IDLE;
            end
            H_READ: begin
               if (link.rd_ack) begin
                  st_ff <= H_IDLE;
                  rd_val_ff <= link.rd_data;
               end
            end
            default: begin
               st_ff <= H_IDLE;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // alert width measurement
   // ----------------------------------------------------------------
   // saturating count so chained reports cannot wrap into a short width
   assign alert_end = link.alert_n && !alert_q_ff;
   assign crc_end = alert_end && (low_cnt_ff <= PAR_LIMIT);

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         alert_q_ff <= 1'b1;
         low_cnt_ff <= 8'h00;
         width_ff <= 8'h00;
      end else begin
         alert_q_ff <= link.alert_n;
         if (!link.alert_n) begin
            low_cnt_ff <= (low_cnt_ff == 8'hff) ? 8'hff : low_cnt_ff + 8'h01;
         end else begin
            low_cnt_ff <= 8'h00;
         end
         if (alert_end) begin
            width_ff <= low_cnt_ff;
         end
      end
   end

   // sticky flags: a new end of pulse beats a software clear
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         crc_seen_ff <= 1'b0;
         par_seen_ff <= 1'b0;
         retry_ff <= 1'b0;
      end else begin
         if (crc_end) begin
            crc_seen_ff <= 1'b1;
         end else if (stat_wr && wb_dat_i[ST_CRC]) begin
            crc_seen_ff <= 1'b0;
         end
         if (alert_end && !crc_end) begin
            par_seen_ff <= 1'b1;
         end else if (stat_wr && wb_dat_i[ST_PAR]) begin
            par_seen_ff <= 1'b0;
         end
         // last burst stays in wdata, so it can be replayed as is
         if (crc_end && ctrl_ff[CTRL_RETRY]) begin
            retry_ff <= 1'b1;
         end else if (st_ff == H_IDLE) begin
            retry_ff <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   assign wb_ack_o = ack_ff;
   assign wb_dat_o = dat_ff;
   assign link.wr_valid = wr_ff;
   assign link.dq = dq_ff;
   assign link.write_mask_pin = pin_ff;
   assign link.column_address_bit_two = a2_ff;
   assign link.mrs_valid = mrs_ff;
   assign link.mrs_sel = MRS_SEL_FIVE;
   assign link.mrs_data = 8'h00;
   assign link.rd_req = rd_ff;
   assign link.rd_sel = rd_sel_ff;
endmodule : wr_crc_controller
`default_nettype wire

// [testbench/wr_crc_link_sva.sv]
// checker: rules seen on the link wires between the two ends
// assumes: placed beside the link, one clock, sync active-low reset
`default_nettype none
module wr_crc_link_sva
   import wr_crc_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic wr_valid,
   input wire logic [7:0] dq,
   input wire logic write_mask_pin,
   input wire logic mrs_valid,
   input wire logic [2:0] mrs_sel,
   input wire logic [7:0] mrs_data,
   input wire logic rd_req,
   input wire logic [7:0] rd_data,
   input wire logic rd_ack,
   input wire logic parity_err,
   input wire logic alert_oe,
   input wire logic alert_n
);
   logic [3:0] beat_ff;
   logic clr_ff;
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   always_ff @(posedge clk_i) begin
      beat_ff <= (!rst_n_i || !wr_valid) ? 4'h0 : beat_ff + 4'h1;
   end
   // a new burst may set the bit again, so the flag only spans idle time
   always_ff @(posedge clk_i) begin
      if (!rst_n_i || wr_valid) begin
         clr_ff <= 1'b0;
      end else if (mrs_valid && mrs_sel == MRS_SEL_FIVE && !mrs_data[MR5_ERR_BIT]) begin
         clr_ff <= 1'b1;
      end
   end
   // ----------------------------------------------------------------
   // sequences and assertions
   // ----------------------------------------------------------------
   sequence crc_start; $rose(alert_oe) && $past(wr_valid); endsequence
   sequence crc_body; alert_oe[*6] ##1 !alert_oe; endsequence
   alert_wire_a: assert property (alert_n == !alert_oe)
      else $error("alert wire level differs from driver");
   crc_pulse_a: assert property (crc_start |-> crc_body)
      else $error("checksum alert not six cycles");
   burst_frame_a: assert property ($rose(wr_valid) |->
      wr_valid[*8] ##1 wr_valid[*2] ##1 !wr_valid) else $error("burst not ten beats");
   filler_ones_a: assert property (wr_valid && beat_ff > 4'h3 |->
      write_mask_pin && (dq == 8'hff || beat_ff == 4'h8)) else $error("filler not ones");
   read_ack_a: assert property (rd_req |=> rd_ack ##1 !rd_ack)
      else $error("read answer not one pulse");
   mirror_bits_a: assert property (rd_ack |-> (rd_data & 8'h77) == 8'h00)
      else $error("status read has stray bits");
   clear_read_a: assert property (rd_ack && clr_ff |-> rd_data == 8'h00)
      else $error("status not cleared");
   alert_quiet_a: assert property (!alert_oe && !wr_valid && !parity_err
      |=> !alert_oe) else $error("alert raised without cause");
endmodule : wr_crc_link_sva
`default_nettype wire

// [testbench/test_write_crc_error_alert.sv]
// testbench: both ends joined by the link, driven over wishbone
// assumes: 20 MHz clock; device mask enable follows control bit six, inversion off
`default_nettype none
module test_write_crc_error_alert
   import wr_crc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk_i, rst_n_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, parity_err_i;
   logic wr_valid_o, crc_err_o, mask_en_i;
   logic [7:0] wb_adr_i;
   logic [3:0] wb_sel_i;
   logic [31:0] wb_dat_i, wb_dat_o, wr_data_o, rd_word, last_wr;
   int bad_count, samples_checked;
   wr_crc_link wr_crc_link_i();
   wr_crc_device wr_crc_device_i(.clk_i, .rst_n_i, .link(wr_crc_link_i), .mask_en_i,
      .inv_en_i(1'b0), .parity_err_i, .wr_data_o, .wr_valid_o, .crc_err_o);
   wr_crc_controller wr_crc_controller_i(.clk_i, .rst_n_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
      .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .link(wr_crc_link_i));
   wr_crc_link_sva wr_crc_link_sva_i(.clk_i, .rst_n_i, .wr_valid(wr_crc_link_i.wr_valid),
      .dq(wr_crc_link_i.dq), .write_mask_pin(wr_crc_link_i.write_mask_pin),
      .mrs_valid(wr_crc_link_i.mrs_valid), .mrs_sel(wr_crc_link_i.mrs_sel),
      .mrs_data(wr_crc_link_i.mrs_data), .rd_req(wr_crc_link_i.rd_req),
      .rd_data(wr_crc_link_i.rd_data), .rd_ack(wr_crc_link_i.rd_ack),
      .alert_oe(wr_crc_link_i.alert_oe), .alert_n(wr_crc_link_i.alert_n),
      .parity_err(parity_err_i));
   // ----------------------------------------------------------------
   // tasks
   // ----------------------------------------------------------------
   task wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= adr;
      wb_dat_i <= dat;
      @(posedge clk_i);
      while (wb_ack_o !== 1'b1) @(posedge clk_i);
      rd_word = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      @(posedge clk_i);
   endtask : wb
   // fixed lead lets the alert and any replay start before polling
   task settle;
      repeat (30) @(posedge clk_i);
      do wb(1'b0, ADR_STAT, 32'h0); while ({rd_word[ST_RETRY], rd_word[ST_BUSY]} !== 2'b00);
   endtask : settle
   task cmp(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         bad_count++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : cmp
   task finish_test;
      $display("mismatches %0d of %0d checks", bad_count, samples_checked);
      if (bad_count == 0 && samples_checked > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : finish_test
   initial begin
      clk_i = 1'b0;
      forever #25 clk_i = ~clk_i;
   end
   always @(posedge clk_i) if (wr_valid_o === 1'b1) last_wr <= wr_data_o;
   initial begin
      repeat (5000) @(posedge clk_i);
      bad_count++;
      finish_test;
   end
   initial begin
      {rst_n_i, wb_cyc_i, wb_stb_i, wb_we_i, parity_err_i, mask_en_i, wb_adr_i, wb_dat_i} = '0;
      wb_sel_i = 4'hf;
      repeat (5) @(posedge clk_i);
      rst_n_i <= 1'b1;
      @(posedge clk_i);
      wb(1'b0, ADR_CTRL, 32'h0);
      cmp(rd_word, CTRL_RST);
      wb(1'b1, ADR_WDATA, 32'hc3a5_0f96);
      wb(1'b1, ADR_CMD, 32'h1);
      settle;
      cmp(rd_word[15:0], 16'h0000);
      cmp(last_wr, 32'hc3a5_0f96);
      wb(1'b1, ADR_CTRL, CTRL_RST | 32'h6);
      wb(1'b1, ADR_CMD, 32'h1);
      settle;
      cmp(rd_word[15:0], 16'h0602);
      cmp(last_wr, 32'hc3a5_0f96);
      cmp(crc_err_o, 1'b1);
      wb(1'b1, ADR_CMD, 32'h4);
      settle;
      cmp(rd_word[23:16], 8'h08);
      wb(1'b1, ADR_CMD, 32'h8);
      settle;
      cmp(rd_word[23:16], 8'h80);
      wb(1'b1, ADR_CMD, 32'h2);
      settle;
      wb(1'b1, ADR_CMD, 32'h4);
      settle;
      cmp(rd_word[23:16], 8'h00);
      cmp(crc_err_o, 1'b0);
      wb(1'b1, ADR_STAT, 32'h6);
      parity_err_i <= 1'b1;
      @(posedge clk_i);
      parity_err_i <= 1'b0;
      repeat (40) @(posedge clk_i);
      settle;
      cmp(rd_word[15:0], 16'h3004);
      // pin values enter both trees once masking is on
      mask_en_i <= 1'b1;
      wb(1'b1, ADR_CTRL, 32'h0000_0560);
      wb(1'b1, ADR_WDATA, 32'h1234_5678);
      wb(1'b1, ADR_CMD, 32'h1);
      settle;
      cmp(rd_word[15:0], 16'h3004);
      cmp(last_wr, 32'h1234_5678);
      // failed burst under masking is held back, no retry
      wb(1'b1, ADR_CTRL, 32'h0000_0544);
      wb(1'b1, ADR_WDATA, 32'ha5a5_5a5a);
      wb(1'b1, ADR_CMD, 32'h1);
      settle;
      cmp(rd_word[15:0], 16'h0606);
      cmp(last_wr, 32'h1234_5678);
      cmp(crc_err_o, 1'b1);
      finish_test;
   end
endmodule : test_write_crc_error_alert
`default_nettype wire
